// File: design/kp_defs.vh
// constants for the key autorepeat and request-cause status block
`ifndef KP_DEFS_VH
`define KP_DEFS_VH

// ***************************************************
// register offsets
// ***************************************************
`define KP_ADDR_W          8
`define KP_OFS_REPEAT_CTL  8'h02
`define KP_OFS_CAUSE_STAT  8'h03

// ***************************************************
// field positions
// ***************************************************
`define KP_RPT_EN_BIT      7
`define KP_RPT_RATE_HI     6
`define KP_RPT_RATE_LO     4
`define KP_RPT_DLY_HI      3
`define KP_RPT_DLY_LO      0
`define KP_ST_PEND_BIT     7
`define KP_ST_ALERT_BIT    6
`define KP_ST_KEY_BIT      5
`define KP_ST_PER_HI       4
`define KP_ST_PER_LO       0

// ***************************************************
// reset values
// ***************************************************
`define KP_RPT_CTL_RST     8'h00
`define KP_PERIOD_RST      5'h00

// ***************************************************
// timing
// ***************************************************
`define KP_CLK_HZ          50000000
`define KP_MS_TICK_US      1000
`define KP_MS_CLKS         ((`KP_MS_TICK_US * (`KP_CLK_HZ / 1000000)))
`define KP_DB_BASE_MS      9
`define KP_DLY_STEP        4'h8
`define KP_RATE_STEP       4'h4

`endif

// File: design/kp_dbtick.v
// debounce-cycle timebase: millisecond divider and cycle-length counter
`timescale 1ns/100ps
`include "kp_defs.vh"
module kp_dbtick #(
  parameter MS_CLKS = `KP_MS_CLKS          // system clocks per millisecond
) (
  // clock and reset
  input  wire       clk_sys_i,
  input  wire       resetn_i,
  // debounce length select, cycle = sel + 9 ms
  input  wire [4:0] db_sel_i,
  // one-cycle pulse at the end of each debounce cycle
  output reg        db_tick_o
);

  reg [19:0] ms_cnt_ff;                    // clocks within one millisecond
  reg [5:0]  db_cnt_ff;                    // milliseconds within one cycle
  wire       ms_end;                       // last clock of a millisecond
  wire [5:0] db_last;                      // last millisecond index

  assign ms_end  = (ms_cnt_ff == MS_CLKS[19:0] - 20'h00001);
  assign db_last = {1'b0, db_sel_i} + 6'h08;   // sel+9 ms, counted from zero

  // ***************************************************
  // millisecond prescaler and cycle counter
  // ***************************************************
  // a change of db_sel_i takes effect at the next cycle end only if the
  // counter is still at or below it; otherwise it runs on to the next wrap
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ms_cnt_ff <= 20'h00000;
      db_cnt_ff <= 6'h00;
      db_tick_o <= 1'b0;
    end else begin
      db_tick_o <= 1'b0;
      if (ms_end) begin
        ms_cnt_ff <= 20'h00000;
        if (db_cnt_ff == db_last) begin   // cycle complete
          db_cnt_ff <= 6'h00;
          db_tick_o <= 1'b1;
        end else begin
          db_cnt_ff <= db_cnt_ff + 6'h01;
        end
      end else begin
        ms_cnt_ff <= ms_cnt_ff + 20'h00001;
      end
    end
  end

endmodule // kp_dbtick

// File: design/kp_repeat_irq.v
// key autorepeat timing and interrupt-cause status registers
// Operation
// R1: autorepeat delay is 8*(field+1) debounce cycles
// R2: repeat period is 4*(field+1) debounce cycles
// R3: key-only request reads pending=1, key=1, alert=0
// R4: alert-only request reads pending=1, alert=1, key=0
// R5: both causes set all three status bits
// R6: no request reads all three bits zero
// R7: control bit 7 enables or disables autorepeat
// R8: status read-only; read clears alert, FIFO-empty clears key
// R9: request every N cycles if new keys seen
// R10: period zero: pin is GPO, status as N=1
// R11: control register resets to all zeros
`timescale 1ns/100ps
`include "kp_defs.vh"
module kp_repeat_irq #(
  parameter MS_CLKS = `KP_MS_CLKS          // system clocks per millisecond
) (
  // clock and reset
  input  wire       clk_sys_i,
  input  wire       resetn_i,
  // register port from the serial interface
  input  wire [7:0] reg_addr_i,
  input  wire       reg_wr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_rd_i,
  output reg  [7:0] reg_rdata_o,
  // debounce timebase select
  input  wire [4:0] db_sel_i,
  // key scanner status
  input  wire       key_new_i,
  input  wire       key_held_i,
  input  wire       fifo_empty_i,
  output reg        key_repeat_o,
  // alert input event and its configuration
  input  wire       alert_evt_i,
  input  wire       alert_int_en_i,
  input  wire       alert_now_i,
  // interrupt pin, open drain, and its GPO level
  input  wire       irq_gpo_lvl_i,
  output wire       irq_pin_o,
  output wire       irq_pin_oe_o
);

  // ***************************************************
  // declarations
  // ***************************************************
  localparam [2:0] ST_IDLE  = 3'b001;      // no key being repeated
  localparam [2:0] ST_DELAY = 3'b010;      // waiting out the first delay
  localparam [2:0] ST_RPT   = 3'b100;      // re-reporting at the rate

  reg  [7:0] rpt_ctl_ff;                   // autorepeat control register
  reg  [4:0] period_ff;                    // key-scan request period field
  reg  [2:0] state_ff;                     // autorepeat state
  reg  [2:0] nxt_state;
  reg  [6:0] rpt_cnt_ff;                   // debounce cycles in this state
  reg  [6:0] nxt_rpt_cnt;
  reg        nxt_key_repeat;
  reg  [4:0] per_cnt_ff;                   // debounce cycles in this period
  reg        key_seen_ff;                  // new or repeated key since last period end
  reg        alert_seen_ff;                // alert waiting for period end
  reg        key_pend_ff;                  // key-scan request pending
  reg        alert_pend_ff;                // alert request pending
  reg        fifo_empty_d_ff;              // previous FIFO-empty level
  wire       db_tick;                      // end of a debounce cycle
  wire [4:0] per_eff;                      // period with zero read as one
  wire       per_end;                      // end of a request period
  wire       rpt_en;                       // autorepeat enable bit
  wire       fifo_drained;                 // FIFO just became empty
  wire       stat_rd;                      // status register read
  wire       key_evt;                      // new or repeated key
  wire       alert_in;                     // enabled alert event
  wire       pend;                         // any request pending

  // last count of a delay or rate window: step*(field+1)-1
  function [6:0] kp_win_last;
    input [3:0] field;
    input [3:0] step;
    reg   [7:0] prod;
    begin
      prod        = ({4'h0, field} + 8'h01) * {4'h0, step};
      kp_win_last = prod[6:0] - 7'h01;
    end
  endfunction

  // ***************************************************
  // debounce-cycle timebase
  // ***************************************************
  kp_dbtick #(
    .MS_CLKS (MS_CLKS)
  ) u_dbtick (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .db_sel_i  (db_sel_i),
    .db_tick_o (db_tick)
  );

  assign rpt_en       = rpt_ctl_ff[`KP_RPT_EN_BIT];
  assign fifo_drained = fifo_empty_i & ~fifo_empty_d_ff;
  assign stat_rd      = reg_rd_i & (reg_addr_i == `KP_OFS_CAUSE_STAT);
  assign key_evt      = key_new_i | key_repeat_o;
  assign alert_in     = alert_evt_i & alert_int_en_i;
  assign per_eff      = (period_ff == 5'h00) ? 5'h01 : period_ff;   // R10
  assign per_end      = db_tick & (per_cnt_ff == per_eff - 5'h01);  // R9
  assign pend         = key_pend_ff | alert_pend_ff;

  // ***************************************************
  // register writes
  // ***************************************************
  // status bits have no storage here, so writes to them simply vanish
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rpt_ctl_ff <= `KP_RPT_CTL_RST;     // R11
      period_ff  <= `KP_PERIOD_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `KP_OFS_REPEAT_CTL) begin
        rpt_ctl_ff <= reg_wdata_i;
      end
      if (reg_addr_i == `KP_OFS_CAUSE_STAT) begin
        period_ff <= reg_wdata_i[`KP_ST_PER_HI:`KP_ST_PER_LO];  // R8
      end
    end
  end

  // ***************************************************
  // register read data
  // ***************************************************
  // registered so the answer is stable one cycle after the read strobe
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `KP_OFS_REPEAT_CTL: begin
          reg_rdata_o <= rpt_ctl_ff;
        end
        `KP_OFS_CAUSE_STAT: begin
          // R3 R4 R5 R6
          reg_rdata_o <= {pend, alert_pend_ff, key_pend_ff, period_ff};
        end
        default: begin
          reg_rdata_o <= 8'h00;          // unmapped reads as zero
        end
      endcase
    end
  end

  // ***************************************************
  // autorepeat state machine, next state
  // ***************************************************
  always @* begin
    nxt_state      = state_ff;
    nxt_rpt_cnt    = rpt_cnt_ff;
    nxt_key_repeat = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (rpt_en && key_new_i) begin   // R7
          nxt_state   = ST_DELAY;
          nxt_rpt_cnt = 7'h00;
        end
      end
      ST_DELAY: begin
        if (!rpt_en || !key_held_i) begin
          nxt_state = ST_IDLE;           // R7
        end else if (key_new_i) begin
          nxt_rpt_cnt = 7'h00;           // a fresh press restarts the delay
        end else if (db_tick) begin
          if (rpt_cnt_ff == kp_win_last(rpt_ctl_ff[`KP_RPT_DLY_HI:`KP_RPT_DLY_LO],
                                        `KP_DLY_STEP)) begin
            nxt_state      = ST_RPT;     // R1
            nxt_rpt_cnt    = 7'h00;
            nxt_key_repeat = 1'b1;
          end else begin
            nxt_rpt_cnt = rpt_cnt_ff + 7'h01;
          end
        end
      end
      ST_RPT: begin
        if (!rpt_en || !key_held_i) begin
          nxt_state = ST_IDLE;           // R7
        end else if (key_new_i) begin
          nxt_state   = ST_DELAY;        // another key takes over
          nxt_rpt_cnt = 7'h00;
        end else if (db_tick) begin
          if (rpt_cnt_ff == kp_win_last({1'b0, rpt_ctl_ff[`KP_RPT_RATE_HI:`KP_RPT_RATE_LO]},
                                        `KP_RATE_STEP)) begin
            nxt_rpt_cnt    = 7'h00;      // R2
            nxt_key_repeat = 1'b1;
          end else begin
            nxt_rpt_cnt = rpt_cnt_ff + 7'h01;
          end
        end
      end
      default: begin
        nxt_state   = ST_IDLE;
        nxt_rpt_cnt = 7'h00;
      end
    endcase
  end

  // ***************************************************
  // autorepeat state machine, registers
  // ***************************************************
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_ff     <= ST_IDLE;
      rpt_cnt_ff   <= 7'h00;
      key_repeat_o <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      rpt_cnt_ff   <= nxt_rpt_cnt;
      key_repeat_o <= nxt_key_repeat;
    end
  end

  // ***************************************************
  // request period counter
  // ***************************************************
  // restarts from zero when the period is rewritten equal to or shorter than the count
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      per_cnt_ff <= 5'h00;
    end else if (per_end || (per_cnt_ff >= per_eff)) begin
      per_cnt_ff <= 5'h00;
    end else if (db_tick) begin
      per_cnt_ff <= per_cnt_ff + 5'h01;
    end
  end

  // ***************************************************
  // cause flags, set wins over clear except in key_seen_ff, where the period end wins
  // ***************************************************
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      key_seen_ff     <= 1'b0;
      alert_seen_ff   <= 1'b0;
      key_pend_ff     <= 1'b0;
      alert_pend_ff   <= 1'b0;
      fifo_empty_d_ff <= 1'b1;
    end else begin
      fifo_empty_d_ff <= fifo_empty_i;
      // new and repeated keys gathered until the period ends; a key in the end cycle
      // is taken by that request directly, so it must not count twice
      if (per_end) begin
        key_seen_ff <= 1'b0;
      end else if (key_evt) begin
        key_seen_ff <= 1'b1;
      end
      // deferred alerts wait for the same period end
      if (alert_in && !alert_now_i) begin
        alert_seen_ff <= 1'b1;
      end else if (per_end) begin
        alert_seen_ff <= 1'b0;
      end
      // key-scan request: only a drained FIFO clears it
      if (per_end && (key_seen_ff || key_evt)) begin
        key_pend_ff <= 1'b1;             // R9
      end else if (fifo_drained) begin
        key_pend_ff <= 1'b0;             // R8
      end
      // alert request: a status read clears it
      if ((alert_in && alert_now_i) || (per_end && alert_seen_ff)) begin
        alert_pend_ff <= 1'b1;
      end else if (stat_rd) begin
        alert_pend_ff <= 1'b0;           // R8
      end
    end
  end

  // ***************************************************
  // interrupt pin
  // ***************************************************
  // active-low open drain: oe high pulls the pin low, pin_o is always 0
  assign irq_pin_o    = 1'b0;
  assign irq_pin_oe_o = (period_ff == 5'h00) ? ~irq_gpo_lvl_i : pend;  // R10

endmodule // kp_repeat_irq

// File: tb/kp_monitor.sv
// checker for the repeat timing and request-cause status block
`timescale 1ns/100ps
module kp_monitor #(
  parameter MS_CLKS = 4                  // clocks per millisecond
) (
  // clock, reset, register port
  input wire       clk_sys_i,
  input wire       resetn_i,
  input wire [7:0] reg_addr_i,
  input wire       reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire       reg_rd_i,
  input wire [7:0] reg_rdata_o,
  // events and request pin
  input wire       key_repeat_o,
  input wire       alert_evt_i,
  input wire       alert_int_en_i,
  input wire       alert_now_i,
  input wire       irq_gpo_lvl_i,
  input wire       irq_pin_oe_o
);
  // ****
  // shadows of written fields
  // ****
  reg [7:0]  ctl_ff;                     // control as written
  reg [4:0]  per_ff;                     // period as written
  reg [15:0] gap_ff;                     // clocks since last repeat, saturating
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ctl_ff <= 8'h00;
      per_ff <= 5'h00;
      gap_ff <= 16'hffff;                // no pulse seen yet, so no spacing check
    end else begin
      if (reg_wr_i && reg_addr_i == 8'h02) ctl_ff <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 8'h03) per_ff <= reg_wdata_i[4:0];
      gap_ff <= key_repeat_o ? 16'h0000 : gap_ff + {15'h0000, ~&gap_ff};
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // ****
  // assertions
  // ****
  rdata_hold_a: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o)) else $error("read data moved");
  ctl_read_a: assert property (reg_rd_i && reg_addr_i == 8'h02 |=> reg_rdata_o == ctl_ff)
    else $error("control readback wrong");
  stat_read_a: assert property (reg_rd_i && reg_addr_i == 8'h03 |=>
    reg_rdata_o[4:0] == per_ff && reg_rdata_o[7] == (reg_rdata_o[6] | reg_rdata_o[5]))
    else $error("status readback wrong");
  bad_read_a: assert property (reg_rd_i && reg_addr_i != 8'h02 && reg_addr_i != 8'h03 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  gpo_level_a: assert property (per_ff == 5'h00 |-> irq_pin_oe_o == !irq_gpo_lvl_i)
    else $error("pin not in output mode");
  alert_now_a: assert property (alert_evt_i && alert_int_en_i && alert_now_i && per_ff != 5'h00
    |=> irq_pin_oe_o) else $error("alert request late");
  pulse_one_a: assert property (key_repeat_o |=> !key_repeat_o) else $error("repeat pulse too long");
  rpt_off_a: assert property (!ctl_ff[7] && !$past(ctl_ff[7]) |-> !key_repeat_o)
    else $error("repeat while disabled");
  rpt_gap_a: assert property (key_repeat_o |-> gap_ff >= 36 * MS_CLKS - 1)
    else $error("repeats too close");
endmodule // kp_monitor
bind kp_repeat_irq kp_monitor #(.MS_CLKS(MS_CLKS)) kp_monitor_i (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .key_repeat_o(key_repeat_o),
  .alert_evt_i(alert_evt_i), .alert_int_en_i(alert_int_en_i), .alert_now_i(alert_now_i),
  .irq_gpo_lvl_i(irq_gpo_lvl_i), .irq_pin_oe_o(irq_pin_oe_o));

// File: tb/kp_host.sv
// host model issuing register strobes toward the block
`timescale 1ns/100ps
module kp_host (
  // clock
  input  wire       clk_sys_i,
  // register strobes
  output reg  [7:0] reg_addr_o,
  output reg        reg_wr_o,
  output reg  [7:0] reg_wdata_o,
  output reg        reg_rd_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
  end
  // one strobed cycle; idle address and data scramble so stale values are never trusted
  task xfer(input bit w, input [7:0] a, input [7:0] d);
    @(posedge clk_sys_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = w;
    reg_rd_o = !w;
    @(posedge clk_sys_i);
    #1;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'($urandom);
    reg_wdata_o = 8'($urandom);
  endtask
endmodule // kp_host

// File: tb/tb_kp_repeat_irq.sv
// self-checking bench for the repeat timing and request-cause status block
`timescale 1ns/100ps
module tb_kp_repeat_irq;
  localparam MS = 4;                     // shortened millisecond
  localparam TK = 9 * MS;                // clocks per debounce cycle at select 0
  reg        clk_sys_i = 1'b0;
  reg        resetn_i = 1'b0;
  reg        key_new = 1'b0, held = 1'b0, fe = 1'b1, aev = 1'b0, aen = 1'b1, anow = 1'b1, lvl = 1'b1;
  reg [4:0]  dsel = 5'h00;               // debounce length select, only ever raised
  wire [7:0] addr, wd, rdata;
  wire       wr, rd, rep, oe, pin;
  int        mismatches = 0, n_compared = 0, cyc = 0, n, d, r, t;
  reg [7:0]  expq[$];                    // expected read data, oldest first
  reg        rd_seen = 1'b0;
  kp_host kp_host_i (.clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wd), .reg_rd_o(rd));
  kp_repeat_irq #(.MS_CLKS(MS)) kp_repeat_irq_i (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wd),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .db_sel_i(dsel), .key_new_i(key_new), .key_held_i(held),
    .fifo_empty_i(fe), .key_repeat_o(rep), .alert_evt_i(aev), .alert_int_en_i(aen),
    .alert_now_i(anow), .irq_gpo_lvl_i(lvl), .irq_pin_o(pin), .irq_pin_oe_o(oe));
  always #10 clk_sys_i = ~clk_sys_i;
  // read data watcher and hang guard
  always @(posedge clk_sys_i) begin
    if (rd_seen) begin
      n_compared++;
      if (rdata !== expq.pop_front()) begin
        mismatches++;
        $display("unexpected at %0t: read data %h", $time, rdata);
      end
    end
    rd_seen <= rd;
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input bit ok);
    n_compared++;
    if (!ok) begin
      mismatches++;
      $display("unexpected at %0t: port value", $time);
    end
  endtask
  task rdx(input [7:0] a, input [7:0] e);
    expq.push_back(e);
    kp_host_i.xfer(1'b0, a, 8'h00);
  endtask
  task wrx(input [7:0] a, input [7:0] v);
    kp_host_i.xfer(1'b1, a, v);
  endtask
  // one pulse on key_new or alert event; for a key, key held and fifo filled
  task pulse(input bit k);
    @(posedge clk_sys_i);
    #1;
    if (k) begin
      fe = 1'b0;
      held = 1'b1;
    end
    key_new = k;
    aev = !k;
    @(posedge clk_sys_i);
    #1;
    key_new = 1'b0;
    aev = 1'b0;
  endtask
  // clocks until a repeat pulse, at most lim
  task wait_rpt(input int lim, output int k);
    k = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end while (rep !== 1'b1 && k < lim);
  endtask
  initial begin
    n = $urandom(32'h8d40);
    repeat (12) @(posedge clk_sys_i);
    #1 resetn_i = 1'b1;
    rdx(8'h02, 8'h00);
    rdx(8'h03, 8'h00);
    rdx(8'h05, 8'h00);
    wrx(8'h03, 8'he1);
    rdx(8'h03, 8'h01);
    wrx(8'h02, 8'($urandom) & 8'h7f);
    pulse(1'b1);
    wait_rpt(10 * TK, n);
    chk(n == 10 * TK);
    rdx(8'h03, 8'ha1);
    chk(oe === 1'b1);
    fe = 1'b1;
    rdx(8'h03, 8'h01);
    chk(oe === 1'b0);
    for (int i = 0; i < 3; i++) begin
      // longer debounce cycle each pass; a shorter one could make the counter wrap
      dsel = dsel + 5'h01;
      t = (9 + dsel) * MS;
      d = $urandom % 16;
      r = $urandom % 8;
      wrx(8'h02, {1'b1, r[2:0], d[3:0]});
      pulse(1'b1);
      wait_rpt(9000, n);
      chk(n > (8 * (d + 1) - 1) * t && n <= 8 * (d + 1) * t);
      wait_rpt(9000, n);
      chk(n == 4 * (r + 1) * t);
      held = 1'b0;
      wait_rpt(40 * t, n);
      chk(n == 40 * t);
      fe = 1'b1;
    end
    wrx(8'h02, 8'h00);
    aen = 1'b0;
    pulse(1'b0);
    rdx(8'h03, 8'h01);
    aen = 1'b1;
    pulse(1'b0);
    chk(oe === 1'b1);
    rdx(8'h03, 8'hc1);
    rdx(8'h03, 8'h01);
    // deferred alert: held back until the period ends
    anow = 1'b0;
    pulse(1'b0);
    chk(oe === 1'b0);
    repeat (2 * TK) @(posedge clk_sys_i);
    rdx(8'h03, 8'hc1);
    anow = 1'b1;
    pulse(1'b1);
    repeat (2 * TK) @(posedge clk_sys_i);
    pulse(1'b0);
    rdx(8'h03, 8'he1);
    rdx(8'h03, 8'ha1);
    fe = 1'b1;
    wrx(8'h03, 8'h00);
    lvl = 1'b0;
    #1 chk(oe === 1'b1);
    @(posedge clk_sys_i);
    #1 lvl = 1'b1;
    #1 chk(oe === 1'b0);
    chk(pin === 1'b0);
    pulse(1'b1);
    repeat (2 * TK) @(posedge clk_sys_i);
    #1 chk(oe === 1'b0);
    rdx(8'h03, 8'ha0);
    tally_and_finish();
  end
endmodule // tb_kp_repeat_irq
